//--- verilog/tcn_params.svh
// tcn_params.svh: register offsets, field positions, reset values and table limits
// assumes inclusion by the torque compensation block and its testbench only
`ifndef TCN_PARAMS_SVH
`define TCN_PARAMS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define TCN_OFS_UNBAL      16'h3607
`define TCN_OFS_FWD_FRIC   16'h3608
`define TCN_OFS_REV_FRIC   16'h3609
`define TCN_OFS_EXPANSION  16'h3610
`define TCN_OFS_DOB_GAIN   16'h3623
`define TCN_OFS_DOB_FILT   16'h3624
`define TCN_OFS_AUTOTUNE   16'h3002
`define TCN_OFS_NOTCH_FREQ 16'h3201
`define TCN_OFS_NOTCH_WID  16'h3202
`define TCN_OFS_NOTCH_DEP  16'h3203
`define TCN_OFS_STATUS     16'h3700

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TCN_BIT_INST_OBS   0
`define TCN_BIT_DOB_EN     1
`define TCN_BIT_DOB_GAIN1  2

// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define TCN_RST_ZERO       16'h0000
`define TCN_RST_FREQ       16'h1388
`define TCN_FREQ_MIN       16'h0032
`define TCN_FREQ_MAX       16'h1387
`define TCN_WID_MAX        16'h0014
`define TCN_DEP_MAX        16'h0064
`define TCN_FILT_SHIFT_MAX 16'h000F

`endif

//--- verilog/tcn_pkg.sv
// tcn_pkg.sv: types shared by the torque compensation block
// assumes tcn_params.svh sits on the include path
package tcn_pkg;
    typedef enum logic [3:0] {
        TCN_MODE_POS    = 4'h1,
        TCN_MODE_SPEED  = 4'h2,
        TCN_MODE_TORQUE = 4'h4,
        TCN_MODE_FULL   = 4'h8
    } tcn_mode_t;

    typedef enum logic [2:0] {
        TCN_FR_HOLD = 3'h1,
        TCN_FR_RUN  = 3'h2,
        TCN_FR_OFF  = 3'h4
    } tcn_fr_state_t;
endpackage

//--- verilog/tcn_torque_comp.sv
// tcn_torque_comp.sv: notch setting decode, disturbance observer and friction offsets
// assumes a register master on a plain strobe port and one 10 MHz clock
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "tcn_params.svh"

module tcn_torque_comp #(
    parameter int W = 16
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    input  wire logic [15:0]       i_addr,
    input  wire logic [W-1:0]      i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [W-1:0]      o_rdata,
    input  wire tcn_pkg::tcn_mode_t i_mode,
    input  wire logic              i_servo_on,
    input  wire logic              i_gain1_sel,
    input  wire logic              i_pos_cmd_valid,
    input  wire logic              i_pos_cmd_fwd,
    input  wire logic signed [W-1:0] i_torque_cmd,
    input  wire logic signed [W-1:0] i_dist_est,
    output logic signed [W-1:0]    o_torque_cmd,
    output logic                   o_notch_active,
    output logic      [W-1:0]      o_notch_bw_x100,
    output logic      [6:0]        o_notch_pass_pct,
    output logic                   o_dob_active
);
    import tcn_pkg::*;

    // ------------------------------------------------------------
    // settings registers
    // ------------------------------------------------------------
    logic [W-1:0] unbal_reg, fwd_reg, rev_reg, exp_reg, gain_reg, filt_reg;
    logic [W-1:0] autotune_reg, freq_reg, wid_reg, dep_reg;

    function automatic logic [W-1:0] clamp(input logic [W-1:0] v, input logic [W-1:0] mx);
        clamp = (v > mx) ? mx : v;
    endfunction

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            unbal_reg    <= `TCN_RST_ZERO;
            fwd_reg      <= `TCN_RST_ZERO;
            rev_reg      <= `TCN_RST_ZERO;
            exp_reg      <= `TCN_RST_ZERO;
            gain_reg     <= `TCN_RST_ZERO;
            filt_reg     <= `TCN_RST_ZERO;
            autotune_reg <= `TCN_RST_ZERO;
            freq_reg     <= `TCN_RST_FREQ;
            wid_reg      <= `TCN_RST_ZERO;
            dep_reg      <= `TCN_RST_ZERO;
        end else if (i_wr) begin
            case (i_addr)
                `TCN_OFS_UNBAL:      unbal_reg    <= i_wdata;
                `TCN_OFS_FWD_FRIC:   fwd_reg      <= i_wdata;
                `TCN_OFS_REV_FRIC:   rev_reg      <= i_wdata;
                `TCN_OFS_EXPANSION:  exp_reg      <= i_wdata;
                `TCN_OFS_DOB_GAIN:   gain_reg     <= i_wdata;
                `TCN_OFS_DOB_FILT:   filt_reg     <= clamp(i_wdata, `TCN_FILT_SHIFT_MAX);
                `TCN_OFS_AUTOTUNE:   autotune_reg <= i_wdata;
                `TCN_OFS_NOTCH_FREQ: freq_reg     <= i_wdata;
                `TCN_OFS_NOTCH_WID:  wid_reg      <= clamp(i_wdata, `TCN_WID_MAX);
                `TCN_OFS_NOTCH_DEP:  dep_reg      <= clamp(i_wdata, `TCN_DEP_MAX);
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // notch setting decode
    // ------------------------------------------------------------
    // ratio x100 per setting; a shift of four base steps doubles the ratio to within one count
    function automatic logic [W-1:0] width_ratio(input logic [4:0] s);
        case (s)
            5'h00:   width_ratio = 16'h0032;
            5'h01:   width_ratio = 16'h003B;
            5'h02:   width_ratio = 16'h0047;
            5'h03:   width_ratio = 16'h0054;
            5'h04:   width_ratio = 16'h0064;
            5'h05:   width_ratio = 16'h0077;
            5'h06:   width_ratio = 16'h008D;
            5'h07:   width_ratio = 16'h00A8;
            5'h08:   width_ratio = 16'h00C8;
            5'h09:   width_ratio = 16'h00EE;
            5'h0A:   width_ratio = 16'h011B;
            5'h0B:   width_ratio = 16'h0150;
            5'h0C:   width_ratio = 16'h0190;
            5'h0D:   width_ratio = 16'h01DC;
            5'h0E:   width_ratio = 16'h0236;
            5'h0F:   width_ratio = 16'h02A1;
            5'h10:   width_ratio = 16'h0320;
            5'h11:   width_ratio = 16'h03B7;
            5'h12:   width_ratio = 16'h046B;
            5'h13:   width_ratio = 16'h0541;
            5'h14:   width_ratio = 16'h0640;
            default: width_ratio = 16'h0640;
        endcase
    endfunction

    // doubling width ratio
    // settings above 20 never reach here; the write port clamps them
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_notch_bw_x100 <= 16'h0032;
        end else begin
            o_notch_bw_x100 <= width_ratio(wid_reg[4:0]);
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_notch_pass_pct <= 7'h00;
        end else begin
            o_notch_pass_pct <= dep_reg[6:0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_notch_active <= 1'b0;
        end else begin
            o_notch_active <= (freq_reg >= `TCN_FREQ_MIN) && (freq_reg <= `TCN_FREQ_MAX);
        end
    end

    // ------------------------------------------------------------
    // disturbance observer
    // ------------------------------------------------------------
    logic dob_cond;
    assign dob_cond = i_servo_on
                    && (i_mode == TCN_MODE_POS || i_mode == TCN_MODE_SPEED)
                    && (autotune_reg == `TCN_RST_ZERO)
                    && !exp_reg[`TCN_BIT_INST_OBS]
                    && exp_reg[`TCN_BIT_DOB_EN]
                    && (!exp_reg[`TCN_BIT_DOB_GAIN1] || i_gain1_sel);

    logic signed [W-1:0] filt_est_reg;
    logic signed [W-1:0] dob_comp;
    logic signed [2*W-1:0] dob_prod;

    // first-order filter, time constant 2^filter cycles
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            filt_est_reg <= '0;
        end else if (!dob_cond) begin
            filt_est_reg <= '0;
        end else begin
            filt_est_reg <= filt_est_reg + ((i_dist_est - filt_est_reg) >>> filt_reg[3:0]);
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dob_active <= 1'b0;
        end else begin
            o_dob_active <= dob_cond;
        end
    end

    // gain in 1/256 steps, 0x0100 is unity; Q8 scaling trades accuracy for no divider
    assign dob_prod = filt_est_reg * $signed({1'b0, gain_reg[W-2:0]});
    assign dob_comp = o_dob_active ? dob_prod[W+7:8] : '0;

    // ------------------------------------------------------------
    // friction torque compensation
    // ------------------------------------------------------------
    tcn_fr_state_t fr_state_reg, fr_state_next;
    logic signed [W-1:0] unbal_app_reg, fric_app_reg;
    logic servo_on_d_reg;
    logic posmode;

    assign posmode = (i_mode == TCN_MODE_POS) || (i_mode == TCN_MODE_FULL);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            servo_on_d_reg <= 1'b0;
        end else begin
            servo_on_d_reg <= i_servo_on;
        end
    end

    always_comb begin
        fr_state_next = fr_state_reg;
        case (fr_state_reg)
            TCN_FR_OFF: begin
                // servo-on in position mode waits for first command
                if (posmode && i_servo_on && !servo_on_d_reg) fr_state_next = TCN_FR_HOLD;
                else if (posmode && i_servo_on) fr_state_next = TCN_FR_RUN;
            end
            TCN_FR_HOLD: begin
                if (!posmode || !i_servo_on) fr_state_next = TCN_FR_OFF;
                else if (i_pos_cmd_valid) fr_state_next = TCN_FR_RUN;
            end
            TCN_FR_RUN: begin
                if (!posmode || !i_servo_on) fr_state_next = TCN_FR_OFF;
            end
            default: fr_state_next = TCN_FR_OFF;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fr_state_reg <= TCN_FR_OFF;
        end else begin
            fr_state_reg <= fr_state_next;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            unbal_app_reg <= '0;
        end else if (i_mode == TCN_MODE_TORQUE) begin
            unbal_app_reg <= '0;
        end else if (!posmode || fr_state_next == TCN_FR_OFF) begin
            unbal_app_reg <= unbal_reg;
        end else if (fr_state_reg != TCN_FR_HOLD || i_pos_cmd_valid) begin
            unbal_app_reg <= unbal_reg;
        end
    end

    // direction friction path, held between commands
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fric_app_reg <= '0;
        end else if (!posmode) begin
            fric_app_reg <= '0;
        end else if (i_pos_cmd_valid && i_servo_on) begin
            fric_app_reg <= i_pos_cmd_fwd ? fwd_reg : rev_reg;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_torque_cmd <= '0;
        end else begin
            o_torque_cmd <= i_torque_cmd + unbal_app_reg + fric_app_reg - dob_comp;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                `TCN_OFS_UNBAL:      o_rdata <= unbal_reg;
                `TCN_OFS_FWD_FRIC:   o_rdata <= fwd_reg;
                `TCN_OFS_REV_FRIC:   o_rdata <= rev_reg;
                `TCN_OFS_EXPANSION:  o_rdata <= exp_reg;
                `TCN_OFS_DOB_GAIN:   o_rdata <= gain_reg;
                `TCN_OFS_DOB_FILT:   o_rdata <= filt_reg;
                `TCN_OFS_AUTOTUNE:   o_rdata <= autotune_reg;
                `TCN_OFS_NOTCH_FREQ: o_rdata <= freq_reg;
                `TCN_OFS_NOTCH_WID:  o_rdata <= wid_reg;
                `TCN_OFS_NOTCH_DEP:  o_rdata <= dep_reg;
                `TCN_OFS_STATUS:     o_rdata <= {13'h0000, fr_state_reg == TCN_FR_HOLD,
                                                 o_notch_active, o_dob_active};
                default:             o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_notch_window: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (freq_reg == `TCN_RST_FREQ) |=> !o_notch_active)
        else $error("notch active at bypass frequency");

    a_width_octave: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (wid_reg == 16'h0014) |=> (o_notch_bw_x100 == 16'h0640))
        else $error("width 20 not ratio 16.00");

    a_depth_pass: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        ##1 (o_notch_pass_pct == $past(dep_reg[6:0])))
        else $error("depth pass ratio mismatch");

    a_dob_servo: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_servo_on |=> !o_dob_active)
        else $error("observer active with servo off");

    a_dob_autotune: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (autotune_reg != 16'h0000) |=> !o_dob_active)
        else $error("observer active with autotuning");

    a_dob_instobs: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        exp_reg[0] |=> !o_dob_active)
        else $error("observer active with speed observer");

    a_dob_enable: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !exp_reg[1] |=> !o_dob_active)
        else $error("observer active while disabled");

    a_dob_gain1: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (exp_reg[2] && !i_gain1_sel) |=> !o_dob_active)
        else $error("observer active outside gain set one");

    a_dob_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !o_dob_active |-> (dob_comp == '0))
        else $error("observer compensation while inactive");

    a_torque_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_mode == TCN_MODE_TORQUE) |=> (unbal_app_reg == '0 && fric_app_reg == '0))
        else $error("offsets applied in torque control");

    a_speed_off: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_mode == TCN_MODE_SPEED && !i_servo_on) |=>
        (fric_app_reg == '0 && unbal_app_reg == $past(unbal_reg)))
        else $error("speed servo-off offsets wrong");

    a_fric_dir: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (posmode && i_servo_on && i_pos_cmd_valid && i_pos_cmd_fwd) |=>
        (fric_app_reg == $past(fwd_reg)))
        else $error("forward friction not selected");

    a_hold_keep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (fr_state_reg == TCN_FR_HOLD && !i_pos_cmd_valid && posmode && i_servo_on) |=>
        $stable(fric_app_reg) && $stable(unbal_app_reg))
        else $error("values changed before first command");

    a_dob_unity: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (o_dob_active && gain_reg == 16'h0100) |-> (dob_comp == filt_est_reg))
        else $error("unity compensation gain not applied");

    sequence s_hold_wait;
        fr_state_reg == TCN_FR_HOLD && posmode && i_servo_on && !i_pos_cmd_valid;
    endsequence
    sequence s_first_cmd;
        fr_state_reg == TCN_FR_HOLD && posmode && i_servo_on && i_pos_cmd_valid;
    endsequence

    a_first_reload: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_hold_wait ##1 s_first_cmd |=> (unbal_app_reg == $past(unbal_reg)) &&
        (fric_app_reg == ($past(i_pos_cmd_fwd) ? $past(fwd_reg) : $past(rev_reg))))
        else $error("first command did not reload offsets");
endmodule

//--- tb/tcn_current_loop.sv
// tcn_current_loop.sv: behavioural current loop past the torque command output
// assumes the block's clock and a load disturbance chosen by the bench
`timescale 1ns/1ps

module tcn_current_loop (
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst,
    input  wire logic signed [15:0] i_torque_ref,
    input  wire logic signed [15:0] i_load_dist,
    output logic signed [15:0]      o_dist_est,
    output logic signed [15:0]      o_applied
);
    // ------------------------------------------------------------
    // current loop lag and disturbance estimate
    // ------------------------------------------------------------
    // one register stands for the loop lag; a real loop is slower still
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_applied <= 16'sh0000;
        end else begin
            o_applied <= i_torque_ref;
        end
    end

    // the estimate trails the load by a cycle, as a real observer would
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dist_est <= 16'sh0000;
        end else begin
            o_dist_est <= i_load_dist;
        end
    end
endmodule

//--- tb/tcn_torque_comp_tb.sv
// tcn_torque_comp_tb.sv: self-checking bench for the torque compensation block
// assumes the register offsets header and a behavioural current loop model
`timescale 1ns/1ps
`include "tcn_params.svh"

module tcn_torque_comp_tb;
    import tcn_pkg::*;
    logic               i_ref_clk;
    logic               i_rst;
    logic [15:0]        i_addr;
    logic [15:0]        i_wdata;
    logic               i_wr;
    logic               i_rd;
    logic [15:0]        o_rdata;
    tcn_mode_t          i_mode;
    logic               i_servo_on;
    logic               i_gain1_sel;
    logic               i_pos_cmd_valid;
    logic               i_pos_cmd_fwd;
    logic signed [15:0] i_torque_cmd;
    logic signed [15:0] load_dist;
    logic signed [15:0] dist_est;
    logic signed [15:0] o_torque_cmd;
    logic               o_notch_active;
    logic [15:0]        o_notch_bw_x100;
    logic [6:0]         o_notch_pass_pct;
    logic               o_dob_active;
    int                 err_count;
    int                 num_checks;
    logic [15:0] bw_tab [21] = '{16'h0032, 16'h003B, 16'h0047, 16'h0054, 16'h0064, 16'h0077,
        16'h008D, 16'h00A8, 16'h00C8, 16'h00EE, 16'h011B, 16'h0150, 16'h0190, 16'h01DC,
        16'h0236, 16'h02A1, 16'h0320, 16'h03B7, 16'h046B, 16'h0541, 16'h0640};
    logic [15:0] fq [4] = '{16'h0031, 16'h0032, 16'h1387, 16'h1388};
    logic        fa [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [15:0] ofs [5] = '{`TCN_OFS_UNBAL, `TCN_OFS_FWD_FRIC, `TCN_OFS_REV_FRIC,
        `TCN_OFS_EXPANSION, `TCN_OFS_DOB_GAIN};

    tcn_torque_comp #(.W(16)) dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mode(i_mode),
        .i_servo_on(i_servo_on), .i_gain1_sel(i_gain1_sel), .i_pos_cmd_valid(i_pos_cmd_valid),
        .i_pos_cmd_fwd(i_pos_cmd_fwd), .i_torque_cmd(i_torque_cmd), .i_dist_est(dist_est),
        .o_torque_cmd(o_torque_cmd), .o_notch_active(o_notch_active),
        .o_notch_bw_x100(o_notch_bw_x100), .o_notch_pass_pct(o_notch_pass_pct),
        .o_dob_active(o_dob_active));

    tcn_current_loop u_loop (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_torque_ref(o_torque_cmd),
        .i_load_dist(load_dist), .o_dist_est(dist_est), .o_applied());

    // ------------------------------------------------------------
    // checks, bus cycles and control steps
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // observer output passes through a filter, so allow a small rounding slack
    task automatic near(input logic signed [15:0] got, input logic signed [15:0] exp);
        num_checks++;
        if ($isunknown(got) || (got - exp > 4) || (exp - got > 4)) begin
            err_count++;
            $display("ERROR at %0t: compensated torque %h expected %h", $time, got, exp);
        end
    endtask

    // a one-cycle gap after each strobe keeps raise and lower in different steps
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp, "read data");
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic set_ctl(input tcn_mode_t m, input logic sv, input logic g1);
        @(posedge i_ref_clk);
        i_mode      <= m;
        i_servo_on  <= sv;
        i_gain1_sel <= g1;
    endtask

    task automatic cmd(input logic fwd);
        @(posedge i_ref_clk);
        i_pos_cmd_valid <= 1'b1;
        i_pos_cmd_fwd   <= fwd;
        @(posedge i_ref_clk);
        i_pos_cmd_valid <= 1'b0;
    endtask

    task automatic dob_case(input tcn_mode_t m, input logic sv, input logic g1,
                            input logic [15:0] at, input logic [15:0] ex, input logic e);
        wr(`TCN_OFS_AUTOTUNE, at);
        wr(`TCN_OFS_EXPANSION, ex);
        set_ctl(m, sv, g1);
        settle(4);
        chk({15'h0000, o_dob_active}, {15'h0000, e}, "observer active");
    endtask

    task automatic trq(input logic [15:0] exp);
        settle(4);
        chk(o_torque_cmd, exp, "torque command");
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    initial begin
        #3000000;
        err_count++;
        $display("ERROR at %0t: run did not finish", $time);
        give_verdict();
    end

    initial begin
        err_count = 0;
        num_checks = 0;
        i_rst = 1'b1;
        {i_wr, i_rd, i_servo_on, i_gain1_sel, i_pos_cmd_valid, i_pos_cmd_fwd} = 6'h00;
        i_addr = 16'h0000;
        i_wdata = 16'h0000;
        i_mode = TCN_MODE_TORQUE;
        i_torque_cmd = 16'sh03E8;
        load_dist = 16'sh0000;
        settle(8);
        chk(o_notch_bw_x100, 16'h0032, "reset width");
        chk({15'h0000, o_notch_active}, 16'h0000, "reset notch");
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rd_chk(`TCN_OFS_NOTCH_FREQ, 16'h1388);
        for (int i = 0; i < 5; i++) begin
            rd_chk(ofs[i], 16'h0000);
            wr(ofs[i], 16'hA5C0 ^ 16'(i));
            rd_chk(ofs[i], 16'hA5C0 ^ 16'(i));
            wr(ofs[i], 16'h0000);
        end
        wr(`TCN_OFS_DOB_FILT, 16'h0014);
        rd_chk(`TCN_OFS_DOB_FILT, 16'h000F);
        rd_chk(16'h1234, 16'h0000);
        $display("register test done");
        for (int i = 0; i < 21; i++) begin
            wr(`TCN_OFS_NOTCH_WID, 16'(i));
            settle(3);
            chk(o_notch_bw_x100, bw_tab[i], "width ratio");
        end
        wr(`TCN_OFS_NOTCH_WID, 16'h0019);
        rd_chk(`TCN_OFS_NOTCH_WID, 16'h0014);
        for (int i = 0; i <= 100; i += 50) begin
            wr(`TCN_OFS_NOTCH_DEP, 16'(i));
            settle(3);
            chk({9'h000, o_notch_pass_pct}, 16'(i), "pass pct");
        end
        wr(`TCN_OFS_NOTCH_DEP, 16'h0078);
        rd_chk(`TCN_OFS_NOTCH_DEP, 16'h0064);
        for (int i = 0; i < 4; i++) begin
            wr(`TCN_OFS_NOTCH_FREQ, fq[i]);
            settle(3);
            chk({15'h0000, o_notch_active}, {15'h0000, fa[i]}, "notch on");
        end
        $display("notch test done");
        dob_case(TCN_MODE_POS, 1'b1, 1'b0, 16'h0000, 16'h0002, 1'b1);
        dob_case(TCN_MODE_SPEED, 1'b1, 1'b0, 16'h0000, 16'h0002, 1'b1);
        dob_case(TCN_MODE_TORQUE, 1'b1, 1'b0, 16'h0000, 16'h0002, 1'b0);
        dob_case(TCN_MODE_FULL, 1'b1, 1'b0, 16'h0000, 16'h0002, 1'b0);
        dob_case(TCN_MODE_POS, 1'b0, 1'b0, 16'h0000, 16'h0002, 1'b0);
        dob_case(TCN_MODE_POS, 1'b1, 1'b0, 16'h0001, 16'h0002, 1'b0);
        dob_case(TCN_MODE_POS, 1'b1, 1'b0, 16'h0000, 16'h0003, 1'b0);
        dob_case(TCN_MODE_POS, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0);
        dob_case(TCN_MODE_POS, 1'b1, 1'b0, 16'h0000, 16'h0006, 1'b0);
        dob_case(TCN_MODE_POS, 1'b1, 1'b1, 16'h0000, 16'h0006, 1'b1);
        $display("observer enable test done");
        wr(`TCN_OFS_UNBAL, 16'h0064);
        wr(`TCN_OFS_FWD_FRIC, 16'h0014);
        wr(`TCN_OFS_REV_FRIC, 16'hFFE2);
        set_ctl(TCN_MODE_TORQUE, 1'b1, 1'b0);
        trq(16'h03E8);
        set_ctl(TCN_MODE_SPEED, 1'b0, 1'b0);
        trq(16'h044C);
        set_ctl(TCN_MODE_POS, 1'b0, 1'b0);
        trq(16'h044C);
        set_ctl(TCN_MODE_POS, 1'b1, 1'b0);
        wr(`TCN_OFS_UNBAL, 16'h00C8);
        trq(16'h044C);
        rd_chk(`TCN_OFS_STATUS, 16'h0004);
        cmd(1'b1);
        trq(16'h04C4);
        settle(10);
        chk(o_torque_cmd, 16'h04C4, "torque held");
        cmd(1'b0);
        trq(16'h0492);
        set_ctl(TCN_MODE_FULL, 1'b1, 1'b0);
        cmd(1'b1);
        trq(16'h04C4);
        set_ctl(TCN_MODE_TORQUE, 1'b1, 1'b0);
        trq(16'h03E8);
        $display("friction test done");
        wr(`TCN_OFS_EXPANSION, 16'h0002);
        set_ctl(TCN_MODE_SPEED, 1'b1, 1'b0);
        load_dist <= 16'sh0200;
        wr(`TCN_OFS_DOB_GAIN, 16'h0080);
        wr(`TCN_OFS_DOB_FILT, 16'h000F);
        wr(`TCN_OFS_DOB_FILT, 16'h0004);
        wr(`TCN_OFS_DOB_FILT, 16'h0000);
        settle(20);
        near(o_torque_cmd, 16'sh03B0);
        rd_chk(`TCN_OFS_STATUS, 16'h0001);
        wr(`TCN_OFS_DOB_GAIN, 16'h0100);
        settle(20);
        near(o_torque_cmd, 16'sh02B0);
        $display("observer gain test done");
        give_verdict();
    end
endmodule
